// ==== inc/dsrc_pkg.sv ====
// Purpose: shared constants and types for divider sync and reset control
// Assumes: ref_clk is the vco divider output clock at 125 MHz
// Notes: long hold times are top-level parameters derived from these figures
package dsrc_pkg;
	// channel layout
	localparam int NUM_CH = 14;
	localparam int DIV_W = 10;
	localparam int PHASE_W = 6;
	localparam int PHASE_LSB = 2;
	localparam int CH_CTRL_W = 8;
	// zero-delay configuration byte: feedback select bit
	localparam int ZD_MODE_BIT = 5;
	// serial control byte: the two soft reset bits
	localparam int SOFT_BIT_A = 2;
	localparam int SOFT_BIT_B = 5;
	localparam logic [7:0] CTRL0_RST = 8'h00;
	// sync pipeline depth in vco divider clocks
	localparam int SYNC_STAGES = 11;
	// timing figures
	localparam int CLK_MHZ = 125;
	localparam int T_POR_MS = 70;
	localparam int T_PIN_STORE_MS = 40;
	localparam int T_PIN_DEF_US = 2;
	localparam int US_PER_MS = 1000;
	localparam int PIN_DEF_CYC = T_PIN_DEF_US * CLK_MHZ;
	// lock detector minimum good periods (2^16)
	localparam int LOCK_MIN_PERIODS = 65536;
	localparam int NUM_PLL = 2;
	localparam int PLL_REF = 0;
	localparam int PLL_DIST = 1;
	localparam logic CAUSE_PIN = 1'b0;
	localparam logic CAUSE_POR = 1'b1;
	// boot and reset sequence states
	typedef enum logic [1:0] {ST_LOAD, ST_WAIT, ST_RUN, ST_SOFT} dsrc_state_t;
endpackage

// ==== hdl/dsrc_chan_div.sv ====
// Purpose: one channel divider with phase preset and gated output
// Assumes: counter runs in half periods of ref_clk, two per clock
// Notes: a divide field of zero means the full range
module dsrc_chan_div #(
	parameter int DW = dsrc_pkg::DIV_W,
	parameter int PW = dsrc_pkg::PHASE_W
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [DW-1:0] div_val,
	input wire logic [PW-1:0] phase,
	input wire logic preset,
	input wire logic en,
	input wire logic freeze,
	output logic clk_out
);
	import dsrc_pkg::*;
	localparam int CW = DW + 2;
	logic [CW-1:0] div_d;
	logic [CW-1:0] hi_q;
	logic [CW-1:0] per_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// divide value and half-period step with wrap
	always_comb
	begin
		div_d = (div_val == '0) ? (CW'(1) << DW) : CW'(div_val);
		cnt_d = cnt_q + CW'(2);
		if (cnt_d >= per_q)
			cnt_d = cnt_d - per_q;
	end

	// settings are taken only at a preset, which starts the first period at the phase
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			hi_q <= '0;
			per_q <= '0;
			cnt_q <= '0;
		end
		else if (preset)
		begin
			hi_q <= div_d; // R5
			per_q <= CW'(div_d << 1);
			cnt_q <= CW'(phase); // R4
		end
		else
			cnt_q <= cnt_d;
	end

	// output flop, held static while frozen
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			clk_out <= 1'b0;
		else if (!freeze)
			clk_out <= en & (cnt_q < hi_q);
	end
endmodule

// ==== hdl/dsrc_top.sv ====
// Purpose: divider sync, zero-delay feedback select, lock detect, reset sequencing
// Assumes: all inputs except sync_pin are synchronous to ref_clk
// Notes: por is a one-cycle power-on pulse; rstn stands for the reset pin
// How it works
// R1 - sync request ORs software bit and pin
// R2 - software sync fires on bit falling edge
// R3 - auto sync on first distribution lock only
// R4 - six-bit phase offset field, half-period steps
// R5 - phase and divide applied only at sync
// R6 - host writes phase, then issues sync
// R7 - pin sync reaches outputs after twelve clocks
// R8 - non-ignoring outputs disabled while sync active
// R9 - ignore-sync channels keep running undisturbed
// R10 - mode bit routes channel zero to feedback
// R11 - external mode feeds feedback clock input
// R12 - lock detector reports unlock on frequency error
// R13 - lock needs 2^16 good detector periods
// R14 - power-on loads store or defaults per pin
// R15 - power-on holds outputs about 70 ms
// R16 - outputs held until calibration and lock
// R17 - reset pin reloads config and syncs outputs
// R18 - pin reset hold 40 ms or 2 us
// R19 - soft reset bits reload, control byte kept
// R20 - soft reset static, bits clear after sclk
// R21 - sync pin passes two-flop synchroniser first
module dsrc_top #(
	parameter int NUM_CH = dsrc_pkg::NUM_CH,
	parameter int LOCK_PERIODS = dsrc_pkg::LOCK_MIN_PERIODS,
	parameter int POR_HOLD_CYC = dsrc_pkg::T_POR_MS * dsrc_pkg::US_PER_MS * dsrc_pkg::CLK_MHZ,
	parameter int STORE_HOLD_CYC = dsrc_pkg::T_PIN_STORE_MS * dsrc_pkg::US_PER_MS
		* dsrc_pkg::CLK_MHZ
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic por,
	input wire logic pd_n,
	input wire logic store_sel,
	input wire logic sync_pin,
	input wire logic sw_sync_bit,
	input wire logic [NUM_CH*dsrc_pkg::CH_CTRL_W-1:0] ch_ctrl,
	input wire logic [NUM_CH*dsrc_pkg::DIV_W-1:0] ch_div,
	input wire logic [NUM_CH-1:0] ch_ignore,
	input wire logic [7:0] zd_cfg,
	input wire logic feedback_clock_in,
	input wire logic vco_cal_done,
	input wire logic [dsrc_pkg::NUM_PLL-1:0] pfd_tick,
	input wire logic [dsrc_pkg::NUM_PLL-1:0] freq_err,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic sclk_tick,
	output logic [NUM_CH-1:0] ch_out,
	output logic n_div_fb,
	output logic [dsrc_pkg::NUM_PLL-1:0] pll_locked,
	output logic sync_active,
	output logic cfg_load,
	output logic cfg_from_store,
	output logic [7:0] ctrl0,
	output logic dev_in_reset
);
	import dsrc_pkg::*;

	dsrc_state_t state_q;
	logic sync_s1_q;
	logic sync_s2_q;
	logic sync_s3_q;
	logic sw_prev_q;
	logic lock_prev_q;
	logic first_lock_q;
	logic pin_rise;
	logic sw_fall;
	logic auto_req;
	logic sync_req;
	logic [SYNC_STAGES-1:0] req_pipe_q;
	logic sync_strobe_q;
	logic sync_busy_q;
	logic cause_q;
	logic load_src_q;
	logic cfg_load_q;
	logic [7:0] ctrl0_q;
	logic [31:0] hold_cnt_q;
	logic [31:0] hold_tgt_q;
	logic hold_done;
	logic soft_go;
	logic boot_run;
	logic freeze;
	logic n_div_fb_q;
	logic [NUM_PLL-1:0] lock_q;

	// phase offset field of one channel control byte
	function automatic logic [PHASE_W-1:0] phase_of(input logic [CH_CTRL_W-1:0] ctrl);
		phase_of = ctrl[PHASE_LSB +: PHASE_W];
	endfunction

	// asynchronous sync pin: two flops, then an edge stage
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			sync_s1_q <= 1'b0;
			sync_s2_q <= 1'b0;
			sync_s3_q <= 1'b0;
		end
		else
		begin
			sync_s1_q <= sync_pin; // R21
			sync_s2_q <= sync_s1_q; // R21
			sync_s3_q <= sync_s2_q;
		end
	end

	// previous values for edge detection
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			sw_prev_q <= 1'b0;
			lock_prev_q <= 1'b0;
		end
		else
		begin
			sw_prev_q <= sw_sync_bit;
			lock_prev_q <= lock_q[PLL_DIST];
		end
	end

	// sources of the primary sync request
	assign pin_rise = sync_s2_q & ~sync_s3_q;
	assign sw_fall = sw_prev_q & ~sw_sync_bit; // R2
	assign auto_req = lock_q[PLL_DIST] & ~lock_prev_q & ~first_lock_q; // R3
	assign sync_req = sw_fall | pin_rise | auto_req; // R1

	// first-lock flag, rearmed only by reset or power-down
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			first_lock_q <= 1'b0;
		else if (por || !pd_n || state_q == ST_SOFT)
			first_lock_q <= 1'b0; // R3
		else if (auto_req)
			first_lock_q <= 1'b1;
	end

	// fixed pipeline from request to divider strobe
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			req_pipe_q <= '0;
			sync_strobe_q <= 1'b0;
		end
		else
		begin
			req_pipe_q <= {req_pipe_q[SYNC_STAGES-2:0], sync_req}; // R7
			sync_strobe_q <= req_pipe_q[SYNC_STAGES-1]; // R7
		end
	end

	// sync active from request until strobe; a new request wins over the clear
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			sync_busy_q <= 1'b0;
		else if (sync_req)
			sync_busy_q <= 1'b1; // R8
		else if (sync_strobe_q)
			sync_busy_q <= 1'b0;
	end

	// lock detectors for the reference cleanup and distribution plls
	generate
		for (genvar p = 0; p < NUM_PLL; p++)
		begin : g_lock
			logic [31:0] good_q;
			always_ff @(posedge ref_clk)
			begin
				if (!rstn || !pd_n)
				begin
					good_q <= '0;
					lock_q[p] <= 1'b0;
				end
				else if (pfd_tick[p])
				begin
					if (freq_err[p])
					begin
						good_q <= '0; // R12
						lock_q[p] <= 1'b0; // R12
					end
					else if (!lock_q[p])
					begin
						if (good_q == 32'(LOCK_PERIODS - 1))
							lock_q[p] <= 1'b1; // R13
						else
							good_q <= good_q + 32'h1; // R13
					end
				end
			end
		end
	endgenerate

	// soft reset request: both reset bits written as one
	assign soft_go = ctrl_wr & ctrl_wdata[SOFT_BIT_A] & ctrl_wdata[SOFT_BIT_B]; // R19

	// boot and reset sequence
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			state_q <= ST_LOAD; // R17
		else if (por)
			state_q <= ST_LOAD; // R14
		else
		begin
			unique case (state_q)
				ST_LOAD: state_q <= ST_WAIT;
				ST_WAIT:
					if (soft_go)
						state_q <= ST_SOFT;
					else if (hold_done && vco_cal_done && lock_q[PLL_DIST])
						state_q <= ST_RUN; // R16
				ST_RUN:
					if (soft_go)
						state_q <= ST_SOFT; // R19
				ST_SOFT:
					if (sclk_tick)
						state_q <= ST_LOAD; // R20
			endcase
		end
	end

	// reset cause picks the output hold time
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			cause_q <= CAUSE_PIN;
		else if (por)
			cause_q <= CAUSE_POR;
		else if (state_q == ST_SOFT)
			cause_q <= CAUSE_PIN;
	end

	// store select caught after release, and config load pulse
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			load_src_q <= 1'b0;
			cfg_load_q <= 1'b0;
		end
		else
		begin
			cfg_load_q <= (state_q == ST_LOAD) & ~por;
			if (state_q == ST_LOAD)
				load_src_q <= store_sel; // R14
		end
	end

	// output hold timer from config load
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			hold_cnt_q <= '0;
			hold_tgt_q <= '0;
		end
		else if (state_q == ST_LOAD)
		begin
			hold_cnt_q <= '0;
			if (cause_q == CAUSE_POR)
				hold_tgt_q <= 32'(POR_HOLD_CYC); // R15
			else if (store_sel)
				hold_tgt_q <= 32'(STORE_HOLD_CYC); // R18
			else
				hold_tgt_q <= 32'(PIN_DEF_CYC); // R18
		end
		else if (state_q == ST_WAIT && !hold_done)
			hold_cnt_q <= hold_cnt_q + 32'h1;
	end

	assign hold_done = hold_cnt_q >= hold_tgt_q;

	// serial control byte: kept through soft reset except the two reset bits
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			ctrl0_q <= CTRL0_RST;
		else if (state_q == ST_SOFT)
		begin
			if (sclk_tick)
			begin
				ctrl0_q[SOFT_BIT_A] <= 1'b0; // R20
				ctrl0_q[SOFT_BIT_B] <= 1'b0; // R20
			end
		end
		else if (ctrl_wr)
			ctrl0_q <= ctrl_wdata; // R19
	end

	// drivers held in sync during boot, static during soft reset
	assign boot_run = state_q == ST_RUN; // R15
	assign freeze = state_q == ST_SOFT; // R20

	// channel dividers
	generate
		for (genvar c = 0; c < NUM_CH; c++)
		begin : g_ch
			dsrc_chan_div #(
				.DW(DIV_W),
				.PW(PHASE_W)
			) u_div (
				.ref_clk(ref_clk),
				.rstn(rstn),
				.div_val(ch_div[c*DIV_W +: DIV_W]),
				.phase(phase_of(ch_ctrl[c*CH_CTRL_W +: CH_CTRL_W])), // R4
				.preset(~boot_run | (sync_strobe_q & ~ch_ignore[c])), // R5 R9
				.en(boot_run & (ch_ignore[c] | ~sync_busy_q)), // R8 R9
				.freeze(freeze),
				.clk_out(ch_out[c])
			);
		end
	endgenerate

	// feedback into the reference cleanup pll n divider
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			n_div_fb_q <= 1'b0;
		else if (zd_cfg[ZD_MODE_BIT])
			n_div_fb_q <= ch_out[0]; // R10
		else
			n_div_fb_q <= feedback_clock_in; // R11
	end

	// outputs
	assign n_div_fb = n_div_fb_q;
	assign pll_locked = lock_q;
	assign sync_active = sync_busy_q;
	assign cfg_load = cfg_load_q;
	assign cfg_from_store = load_src_q;
	assign ctrl0 = ctrl0_q;
	assign dev_in_reset = ~boot_run;

	// checks on the sync path, lock detect and reset sequence
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	a_or_request: assert property ((sw_fall || pin_rise || auto_req) |=> req_pipe_q[0]) // R1
		else $error("sync source did not raise request");
	a_sw_falling: assert property ($rose(sw_sync_bit) && !pin_rise && !auto_req
		|=> !req_pipe_q[0]) // R2
		else $error("software sync fired on rising bit");
	a_auto_once: assert property (first_lock_q && lock_q[PLL_DIST] && !lock_prev_q // R3
		&& !sw_fall && !pin_rise |=> !req_pipe_q[0])
		else $error("auto sync repeated without reset");
	a_pin_latency: assert property (pin_rise |-> ##12 sync_strobe_q) // R7
		else $error("pin sync strobe latency wrong");
	a_busy_gate: assert property (sync_busy_q && !freeze // R8
		|=> (ch_out & ~$past(ch_ignore)) == '0)
		else $error("output ran during sync");
	a_zd_internal: assert property (zd_cfg[ZD_MODE_BIT] |=> n_div_fb == $past(ch_out[0])) // R10
		else $error("internal feedback not channel zero");
	a_zd_external: assert property (!zd_cfg[ZD_MODE_BIT]
		|=> n_div_fb == $past(feedback_clock_in)) // R11
		else $error("external feedback not routed");
	a_unlock_err: assert property (pd_n && pfd_tick[0] && freq_err[0]
		|=> !pll_locked[0]) // R12
		else $error("unlock not reported on error");
	a_lock_cause: assert property ($rose(pll_locked[0])
		|-> $past(pfd_tick[0]) && !$past(freq_err[0])) // R13
		else $error("lock without good detector period");
	a_load_source: assert property (state_q == ST_LOAD && !por
		|=> cfg_from_store == $past(store_sel) ##0 cfg_load) // R14
		else $error("config source not captured");
	a_boot_hold: assert property (state_q == ST_WAIT |=> ch_out == '0) // R15
		else $error("output toggled during boot hold");
	a_run_entry: assert property ($rose(boot_run)
		|-> $past(vco_cal_done) && $past(lock_q[PLL_DIST])) // R16
		else $error("outputs released before cal and lock");
	a_soft_entry: assert property (soft_go && !por && state_q != ST_SOFT
		&& state_q != ST_LOAD |=> freeze && ctrl0 == $past(ctrl_wdata)) // R19
		else $error("soft reset not entered");
	a_soft_clear: assert property (freeze && sclk_tick && !por
		|=> !ctrl0[SOFT_BIT_A] && !ctrl0[SOFT_BIT_B] && state_q == ST_LOAD) // R20
		else $error("soft reset bits did not clear");

	c_pin_sync: cover property (pin_rise ##12 sync_strobe_q);
	c_boot_run: cover property ($rose(boot_run));
	c_soft_reset: cover property (freeze ##1 state_q == ST_LOAD);
	c_first_lock: cover property (auto_req);
endmodule

// ==== sim/dsrc_host_model.sv ====
// Purpose: host side model, phase detector and serial clock strobes
// Assumes: each strobe is one ref_clk cycle wide
// Notes: serial clock stands still while sclk_run is low
module dsrc_host_model #(
	parameter int PFD_DIV = 2,
	parameter int SCLK_DIV = 8
) (
	input wire logic ref_clk,
	input wire logic sclk_run,
	output logic [1:0] pfd_tick,
	output logic sclk_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	int pc = 0;
	int sc = 0;
	// detector period strobe for both loops
	always @(posedge ref_clk)
	begin
		pc <= (pc == PFD_DIV - 1) ? 0 : pc + 1;
		pfd_tick <= {2{pc == 0}};
	end
	// completed serial clock cycles, only during a transfer
	always @(posedge ref_clk)
	begin
		sc <= sclk_run ? ((sc == SCLK_DIV - 1) ? 0 : sc + 1) : 0;
		sclk_tick <= sclk_run && (sc == SCLK_DIV - 1);
	end
endmodule

// ==== sim/dsrc_top_tb.sv ====
// Purpose: self-checking bench for divider sync and reset control
// Assumes: short hold and lock counts set by parameter
// Notes: inputs change by non-blocking assignment at the rising edge
module dsrc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dsrc_pkg::*;
	localparam int HOLD = 30;
	localparam int POR = 40;
	logic ref_clk, rstn, por, pd_n, store_sel, sync_pin, sw_sync_bit;
	logic feedback_clock_in, vco_cal_done, ctrl_wr, sclk_run, sclk_tick;
	logic n_div_fb, sync_active, cfg_load, cfg_from_store, dev_in_reset;
	logic [NUM_CH*CH_CTRL_W-1:0] ch_ctrl;
	logic [NUM_CH*DIV_W-1:0] ch_div;
	logic [NUM_CH-1:0] ch_ignore, ch_out;
	logic [7:0] zd_cfg, ctrl_wdata, ctrl0;
	logic [1:0] pfd_tick, freq_err, pll_locked;
	int mismatches = 0;
	int samples_checked = 0;
	int n, t0, tog, cycles = 0;

	dsrc_top #(.LOCK_PERIODS(8), .POR_HOLD_CYC(POR), .STORE_HOLD_CYC(HOLD)) dsrc_top_i (
		.ref_clk, .rstn, .por, .pd_n, .store_sel, .sync_pin, .sw_sync_bit, .ch_ctrl,
		.ch_div, .ch_ignore, .zd_cfg, .feedback_clock_in, .vco_cal_done, .pfd_tick,
		.freq_err, .ctrl_wr, .ctrl_wdata, .sclk_tick, .ch_out, .n_div_fb, .pll_locked,
		.sync_active, .cfg_load, .cfg_from_store, .ctrl0, .dev_in_reset);
	dsrc_host_model dsrc_host_model_i (.ref_clk, .sclk_run, .pfd_tick, .sclk_tick);

	// clock and cycle count
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// edge count updated after the edge, so a read at the edge sees the old count
	always @(posedge ref_clk) cycles <= cycles + 1;

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// latency or count within a window
	task automatic chk_in(input string what, input int lo, input int hi, input int got);
		samples_checked++;
		if (got < lo || got > hi)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic idle(input int k);
		repeat (k) @(negedge ref_clk);
	endtask

	// bounded wait on one status output
	task automatic wait_for(input int sel, input logic val, input int bound, output int c);
		logic s;
		c = 0;
		do
		begin
			@(negedge ref_clk);
			c++;
			case (sel)
				0: s = sync_active;
				1: s = pll_locked[1];
				2: s = dev_in_reset;
				default: s = (ctrl0 !== 8'hA5);
			endcase
		end
		while (s !== val && c < bound);
		if (s !== val)
		begin
			mismatches++;
			$display("CHECK FAILED wait %0d expected %0b seen %0b", sel, val, s);
			final_report();
		end
	endtask

	task automatic final_report();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// main sequence
	initial
	begin
		{rstn, por, sync_pin, sw_sync_bit, ctrl_wr, sclk_run, feedback_clock_in} = '0;
		{pd_n, store_sel, vco_cal_done} = 3'b111;
		freq_err = '0;
		zd_cfg = '0;
		ctrl_wdata = '0;
		ch_ignore = 14'h0002;
		ch_ctrl = {NUM_CH{8'h0C}};
		ch_div = {NUM_CH{10'h002}};
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("ctrl0", CTRL0_RST, ctrl0);
		chk("in_reset", 8'h01, 8'(dev_in_reset));
		@(posedge ref_clk);
		rstn <= 1'b1;
		t0 = cycles;
		idle(2);
		chk("cfg_load", 8'h01, 8'(cfg_load));
		chk("from_store", 8'h01, 8'(cfg_from_store));
		wait_for(1, 1'b1, 100, n);
		wait_for(0, 1'b1, 3, n);
		wait_for(2, 1'b0, 100, n);
		chk_in("hold", HOLD, HOLD + 10, cycles - t0);
		@(posedge ref_clk);
		sync_pin <= 1'b1;
		ch_ctrl[2*CH_CTRL_W +: CH_CTRL_W] <= 8'h00;
		wait_for(0, 1'b1, 8, n);
		chk_in("pin_rise", 3, 5, n);
		chk("phase_held", 8'h00, 8'(ch_out[2] ^ ch_out[3]));
		idle(3);
		tog = 0;
		repeat (6)
		begin
			t0 = ch_out[1];
			@(negedge ref_clk);
			tog += (ch_out[1] !== t0[0]);
			chk("gated", 8'h00, 8'(ch_out[2]));
		end
		chk_in("ignore_tog", 1, 6, tog);
		wait_for(0, 1'b0, 20, t0);
		chk_in("pin_span", 14, 18, n + 3 + 6 + t0);
		@(posedge ref_clk);
		sync_pin <= 1'b0;
		sw_sync_bit <= 1'b1;
		idle(4);
		chk("sw_set", 8'h00, 8'(sync_active));
		chk("phase_new", 8'h01, 8'(ch_out[2] ^ ch_out[3]));
		@(posedge ref_clk);
		sw_sync_bit <= 1'b0;
		wait_for(0, 1'b1, 4, n);
		wait_for(0, 1'b0, 20, n);
		@(posedge ref_clk);
		feedback_clock_in <= 1'b1;
		idle(3);
		chk("fb_ext", 8'h01, 8'(n_div_fb));
		@(posedge ref_clk);
		zd_cfg <= 8'h20;
		tog = 0;
		repeat (8)
		begin
			@(negedge ref_clk);
			tog += (n_div_fb === 1'b0);
		end
		chk_in("fb_int", 1, 7, tog);
		@(posedge ref_clk);
		freq_err <= 2'b11;
		wait_for(1, 1'b0, 10, n);
		@(posedge ref_clk);
		freq_err <= 2'b00;
		wait_for(1, 1'b1, 60, n);
		idle(3);
		chk("no_resync", 8'h00, 8'(sync_active));
		@(posedge ref_clk);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= 8'hA5;
		@(posedge ref_clk);
		ctrl_wr <= 1'b0;
		idle(5);
		chk("soft_hold", 8'hA5, ctrl0);
		chk("soft_rst", 8'h01, 8'(dev_in_reset));
		@(posedge ref_clk);
		sclk_run <= 1'b1;
		wait_for(3, 1'b1, 20, n);
		chk("soft_clr", 8'h81, ctrl0);
		wait_for(2, 1'b0, 100, n);
		// power-on pulse with the store pin low
		@(posedge ref_clk);
		por <= 1'b1;
		store_sel <= 1'b0;
		t0 = cycles;
		@(posedge ref_clk);
		por <= 1'b0;
		wait_for(2, 1'b0, 100, n);
		chk_in("por_hold", POR, POR + 10, cycles - t0);
		chk("por_src", 8'h00, 8'(cfg_from_store));
		// pin reset in mid-run, defaults path, rearms the first-lock sync
		@(posedge ref_clk);
		rstn <= 1'b0;
		@(posedge ref_clk);
		rstn <= 1'b1;
		t0 = cycles;
		wait_for(1, 1'b1, 100, n);
		wait_for(0, 1'b1, 3, n);
		wait_for(2, 1'b0, PIN_DEF_CYC + 20, n);
		chk_in("pin_def_hold", PIN_DEF_CYC, PIN_DEF_CYC + 10, cycles - t0);
		final_report();
	end
endmodule
